// [design/adcs_map.vh]
/*
 * register offsets, field positions, reset values and state counts for
 * the converter sequencer control block.
 * assumes an 8-bit cpu bus with a 4-bit register offset and a clock of
 * one state per edge.
 */
`ifndef ADCS_MAP_VH
`define ADCS_MAP_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the 8-bit bus)
// ----------------------------------------------------------------------
`define ADCS_OFF_RES_A_HI    4'h0
`define ADCS_OFF_RES_A_LO    4'h1
`define ADCS_OFF_RES_B_HI    4'h2
`define ADCS_OFF_RES_B_LO    4'h3
`define ADCS_OFF_RES_C_HI    4'h4
`define ADCS_OFF_RES_C_LO    4'h5
`define ADCS_OFF_RES_D_HI    4'h6
`define ADCS_OFF_RES_D_LO    4'h7
`define ADCS_OFF_CTRL_STATUS 4'h8
`define ADCS_OFF_TRIG_CTRL   4'h9

// ----------------------------------------------------------------------
// conv_ctrl_status fields
// ----------------------------------------------------------------------
`define ADCS_BIT_END_FLAG    7
`define ADCS_BIT_IRQ_ENABLE  6
`define ADCS_BIT_START       5
`define ADCS_BIT_SCAN        4
`define ADCS_BIT_TIME_SEL    3
`define ADCS_BIT_GROUP       2
`define ADCS_BIT_CHAN_HI     1
`define ADCS_BIT_CHAN_LO     0

// ext_trigger_ctrl fields
`define ADCS_BIT_TRIG_ENABLE 7
`define ADCS_TRIG_RSVD_BITS  7'h7f

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ADCS_RST_CTRL_STATUS 8'h00
`define ADCS_RST_TRIG_CTRL   8'h7f
`define ADCS_RST_RESULT      10'h000
`define ADCS_RD_UNMAPPED     8'h00

// ----------------------------------------------------------------------
// conversion timing, in states (one state per clock edge)
// ----------------------------------------------------------------------
`define ADCS_LEN_FIRST_SLOW  9'h10a
`define ADCS_LEN_FIRST_FAST  9'h086
`define ADCS_LEN_NEXT_SLOW   9'h100
`define ADCS_LEN_NEXT_FAST   9'h080
`define ADCS_SAMPLE_SLOW     9'h050
`define ADCS_SAMPLE_FAST     9'h028
`define ADCS_STEP_LAST_SLOW  4'hf
`define ADCS_STEP_LAST_FAST  4'h7
`define ADCS_SAR_FIRST_TRIAL 10'h200
`define ADCS_SAR_TOP_BIT     4'h9

`endif

// [design/adcs_sar.v]
/*
 * successive approximation engine: one 10-bit conversion per go pulse.
 * assumes the comparator input is synchronous and reports analog input
 * at or above the trial code on dac_code; clear is synchronous.
 */
`timescale 1ns/1ns
`include "adcs_map.vh"

module adcs_sar (
    input  wire       clock,
    input  wire       sync_clear,
    input  wire       go,
    input  wire       abort,
    input  wire       fast,
    input  wire       first,
    input  wire       cmp_high,
    output reg        done,
    output reg  [9:0] result,
    output reg  [9:0] dac_code,
    output reg        sampling
);

    reg       busy;
    reg       decided;
    reg [8:0] cnt;
    reg [8:0] len_m1;
    reg [8:0] spl_m1;
    reg [3:0] step_last;
    reg [3:0] step_cnt;
    reg [3:0] bit_idx;

    // ------------------------------------------------------------------
    // sample window, then one trial per bit, top bit first
    // ------------------------------------------------------------------
    // the total length is fixed by the counter, not by the bit steps, so
    // a later change to the step size cannot shift the end of conversion
    always @(posedge clock) begin
        if (sync_clear) begin
            busy      <= 1'b0;
            decided   <= 1'b0;
            done      <= 1'b0;
            sampling  <= 1'b0;
            cnt       <= 9'h000;
            len_m1    <= 9'h000;
            spl_m1    <= 9'h000;
            step_last <= 4'h0;
            step_cnt  <= 4'h0;
            bit_idx   <= 4'h0;
            result    <= `ADCS_RST_RESULT;
            dac_code  <= `ADCS_RST_RESULT;
        end else begin
            done <= 1'b0;
            if (go) begin
                busy      <= 1'b1;
                decided   <= 1'b0;
                sampling  <= 1'b1;
                cnt       <= 9'h000;
                step_cnt  <= 4'h0;
                bit_idx   <= `ADCS_SAR_TOP_BIT;
                dac_code  <= `ADCS_SAR_FIRST_TRIAL;
                step_last <= fast ? `ADCS_STEP_LAST_FAST : `ADCS_STEP_LAST_SLOW;
                spl_m1    <= (fast ? `ADCS_SAMPLE_FAST : `ADCS_SAMPLE_SLOW) - 9'h001;
                if (first)
                    len_m1 <= (fast ? `ADCS_LEN_FIRST_FAST : `ADCS_LEN_FIRST_SLOW) - 9'h001;
                else
                    len_m1 <= (fast ? `ADCS_LEN_NEXT_FAST : `ADCS_LEN_NEXT_SLOW) - 9'h001;
            end else if (abort) begin
                busy     <= 1'b0;
                sampling <= 1'b0;
            end else if (busy) begin
                cnt <= cnt + 9'h001;
                if (sampling) begin
                    if (cnt == spl_m1)
                        sampling <= 1'b0;
                end else if (!decided) begin
                    // keep or drop the trial bit, then try the next one [R1]
                    if (step_cnt == step_last) begin
                        step_cnt          <= 4'h0;
                        dac_code[bit_idx] <= cmp_high;
                        if (bit_idx == 4'h0) begin
                            decided <= 1'b1;
                        end else begin
                            dac_code[bit_idx - 4'h1] <= 1'b1;
                            bit_idx                  <= bit_idx - 4'h1;
                        end
                    end else begin
                        step_cnt <= step_cnt + 4'h1;
                    end
                end
                if (cnt == len_m1) begin
                    busy   <= 1'b0;
                    done   <= 1'b1;
                    result <= dac_code; // [R1]
                end
            end
        end
    end

endmodule

// [design/adcs_ctrl.v]
/*
 * control and status of an eight-input, two-group converter: mode and
 * channel sequencing, end flag, interrupt request, external trigger and
 * the 8-bit read path of the four 16-bit result registers.
 * assumes a cpu bus with one-cycle rd_en / wr_en strobes synchronous to
 * clock, a comparator answering dac_code, and standby as a level input.
 */
// How it works
// R1: ten-bit successive approximation per conversion
// R2: end flag set at single end, scan end
// R3: flag cleared by zero write after read
// R4: interrupt enable gates the end request
// R5: start bit high while converting; zero stops (here a zero write in the same cycle as an enabled trigger edge does not stop)
// R6: trigger falling edge sets start like software
// R7: single mode clears start when done
// R8: scan repeats until start cleared, reset, standby
// R9: mode bit zero single, one scan
// R10: software stops before changing mode or channel
// R11: time select picks 266 or 134 states
// R12: group bit plus channel; scan covers 0..n
// R13: trigger enable one honours pin, zero ignores
// R14: trigger register low bits read one
// R15: trigger register resets to 7f, standby too
// R16: upper byte read latches lower byte
// R17: lower byte read returns the latch
// R18: software reads upper byte before lower
// R19: result high byte, two bits, zeros below
// R20: channel pairs map to registers a..d; cleared
// R21: status register clears on reset and standby
// R22: scan starts at group head, back to back
// R23: irq level is end flag and enable
`timescale 1ns/1ns
`include "adcs_map.vh"

module adcs_ctrl (
    input  wire       clock,
    input  wire       rst_n,
    input  wire       standby,
    input  wire [3:0] addr,
    input  wire       rd_en,
    input  wire       wr_en,
    input  wire [7:0] wdata,
    output reg  [7:0] rdata,
    input  wire       ext_trigger_pin_n,
    input  wire       cmp_high,
    output wire [9:0] dac_code,
    output wire       sample_hold,
    output reg  [2:0] analog_chan_sel,
    output reg        conv_end_irq
);

    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;
    // whole-register reset images, so single bits can be picked out
    localparam [7:0] CSR_RESET = `ADCS_RST_CTRL_STATUS;
    localparam [7:0] TRG_RESET = `ADCS_RST_TRIG_CTRL;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg        state;
    reg        conv_end_flag;
    reg        end_irq_enable;
    reg        conv_start_bit;
    reg        scan_mode;
    reg        conv_time_select;
    reg        group_select;
    reg  [1:0] chan_select;
    reg        ext_trigger_enable;
    reg        clear_armed;
    reg        trig_prev;
    reg  [1:0] chan_idx;
    reg  [7:0] temp_lo;

    reg        next_state;
    reg        next_flag;
    reg        next_irq_enable;
    reg        next_start;
    reg        next_scan;
    reg        next_time_sel;
    reg        next_group;
    reg  [1:0] next_chan_sel;
    reg        next_trig_enable;
    reg        next_armed;
    reg  [1:0] next_chan_idx;
    reg        go;
    reg        go_first;
    reg        abort;
    reg  [9:0] hi_word;

    wire        clear = ~rst_n | standby;
    wire        sar_done;
    wire [9:0]  sar_result;
    wire [39:0] res_word;

    wire csr_wr   = wr_en & (addr == `ADCS_OFF_CTRL_STATUS);
    wire csr_rd   = rd_en & (addr == `ADCS_OFF_CTRL_STATUS);
    wire trg_wr   = wr_en & (addr == `ADCS_OFF_TRIG_CTRL);
    // pin is sampled as synchronous, so one register finds the edge
    wire trig_hit = ext_trigger_enable & trig_prev & ~ext_trigger_pin_n; // [R13]
    wire sw_start = csr_wr & wdata[`ADCS_BIT_START];
    wire sw_stop  = csr_wr & ~wdata[`ADCS_BIT_START] & ~trig_hit;
    wire seq_done = (state == ST_CONV) & sar_done;
    wire at_last  = ~scan_mode | (chan_idx == chan_select);

    // ------------------------------------------------------------------
    // next values of control state
    // ------------------------------------------------------------------
    // mode, time and channel take a written value at once; a start in the
    // same write uses the new values, so both may be set together
    always @* begin
        next_state       = state;
        next_flag        = conv_end_flag;
        next_irq_enable  = end_irq_enable;
        next_start       = conv_start_bit;
        next_scan        = scan_mode;
        next_time_sel    = conv_time_select;
        next_group       = group_select;
        next_chan_sel    = chan_select;
        next_trig_enable = ext_trigger_enable;
        next_armed       = clear_armed;
        next_chan_idx    = chan_idx;
        go               = 1'b0;
        go_first         = 1'b0;
        abort            = 1'b0;

        if (csr_wr) begin
            next_irq_enable = wdata[`ADCS_BIT_IRQ_ENABLE];
            next_scan       = wdata[`ADCS_BIT_SCAN];     // [R9]
            next_time_sel   = wdata[`ADCS_BIT_TIME_SEL]; // [R11]
            next_group      = wdata[`ADCS_BIT_GROUP];    // [R12]
            next_chan_sel   = wdata[`ADCS_BIT_CHAN_HI:`ADCS_BIT_CHAN_LO];
        end
        if (trg_wr)
            next_trig_enable = wdata[`ADCS_BIT_TRIG_ENABLE]; // [R13]

        // a read that sees the flag high arms the clear [R3]
        if (csr_rd & conv_end_flag)
            next_armed = 1'b1;
        if (csr_wr & ~wdata[`ADCS_BIT_END_FLAG]) begin
            if (clear_armed)
                next_flag = 1'b0; // [R3]
            next_armed = 1'b0;
        end

        if (state == ST_IDLE) begin
            // software write of one and trigger edge start alike [R6]
            if (sw_start | trig_hit) begin
                next_start    = 1'b1;                          // [R5]
                next_state    = ST_CONV;
                next_chan_idx = next_scan ? 2'h0 : next_chan_sel; // [R12] [R22]
                go            = 1'b1;
                go_first      = 1'b1;
            end
        end else begin
            if (seq_done) begin
                if (at_last)
                    next_flag = 1'b1; // [R2]
                if (~scan_mode) begin
                    next_start = 1'b0; // [R7]
                    next_state = ST_IDLE;
                end else if (sw_stop) begin
                    next_start = 1'b0;
                    next_state = ST_IDLE;
                end else begin
                    // next channel starts on the edge after the one the last ends on [R8] [R22]
                    next_chan_idx = at_last ? 2'h0 : chan_idx + 2'h1;
                    go            = 1'b1;
                end
            end else if (sw_stop) begin
                next_start = 1'b0; // [R5]
                next_state = ST_IDLE;
                abort      = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // control registers; standby acts as a reset
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (clear) begin
            state              <= ST_IDLE;
            conv_end_flag      <= CSR_RESET[`ADCS_BIT_END_FLAG]; // [R21]
            end_irq_enable     <= 1'b0;
            conv_start_bit     <= 1'b0; // [R8]
            scan_mode          <= 1'b0;
            conv_time_select   <= 1'b0;
            group_select       <= 1'b0;
            chan_select        <= 2'h0;
            ext_trigger_enable <= TRG_RESET[`ADCS_BIT_TRIG_ENABLE]; // [R15]
            clear_armed        <= 1'b0;
            trig_prev          <= 1'b1;
            chan_idx           <= 2'h0;
            analog_chan_sel    <= 3'h0;
            conv_end_irq       <= 1'b0;
        end else begin
            state              <= next_state;
            conv_end_flag      <= next_flag;
            end_irq_enable     <= next_irq_enable;
            conv_start_bit     <= next_start;
            scan_mode          <= next_scan;
            conv_time_select   <= next_time_sel;
            group_select       <= next_group;
            chan_select        <= next_chan_sel;
            ext_trigger_enable <= next_trig_enable;
            clear_armed        <= next_armed;
            trig_prev          <= ext_trigger_pin_n;
            chan_idx           <= next_chan_idx;
            if (go)
                analog_chan_sel <= {next_group, next_chan_idx}; // [R12]
            // level request, withdrawn as soon as either bit drops [R4] [R23]
            conv_end_irq       <= next_flag & next_irq_enable;
        end
    end

    // ------------------------------------------------------------------
    // conversion engine
    // ------------------------------------------------------------------
    adcs_sar u_sar (
        .clock      (clock),
        .sync_clear (clear),
        .go         (go),
        .abort      (abort),
        .fast       (next_time_sel), // [R11]
        .first      (go_first),
        .cmp_high   (cmp_high),
        .done       (sar_done),
        .result     (sar_result),
        .dac_code   (dac_code),
        .sampling   (sample_hold)
    );

    // ------------------------------------------------------------------
    // result registers a..d, one per channel pair
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_res
            reg [9:0] val;
            always @(posedge clock) begin
                if (clear)
                    val <= `ADCS_RST_RESULT; // [R20]
                else if (seq_done && (chan_idx == gi))
                    val <= sar_result; // [R20]
            end
            assign res_word[gi*10 +: 10] = val;
        end
    endgenerate

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    always @* begin
        case (addr[2:1])
            2'h0:    hi_word = res_word[9:0];
            2'h1:    hi_word = res_word[19:10];
            2'h2:    hi_word = res_word[29:20];
            2'h3:    hi_word = res_word[39:30];
            default: hi_word = res_word[9:0];
        endcase
    end

    // lower byte goes via the latch so a result landing between the two
    // byte reads cannot tear the pair; a lone lower read is stale
    always @(posedge clock) begin
        if (clear) begin
            rdata   <= 8'h00;
            temp_lo <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `ADCS_OFF_RES_A_HI, `ADCS_OFF_RES_B_HI,
                `ADCS_OFF_RES_C_HI, `ADCS_OFF_RES_D_HI: begin
                    rdata   <= hi_word[9:2];          // [R16] [R19]
                    temp_lo <= {hi_word[1:0], 6'h00}; // [R16] [R19]
                end
                `ADCS_OFF_RES_A_LO, `ADCS_OFF_RES_B_LO,
                `ADCS_OFF_RES_C_LO, `ADCS_OFF_RES_D_LO: begin
                    rdata <= temp_lo; // [R17]
                end
                `ADCS_OFF_CTRL_STATUS: begin
                    rdata <= {conv_end_flag, end_irq_enable, conv_start_bit, scan_mode,
                              conv_time_select, group_select, chan_select};
                end
                `ADCS_OFF_TRIG_CTRL: begin
                    rdata <= {ext_trigger_enable, `ADCS_TRIG_RSVD_BITS}; // [R14]
                end
                default: begin
                    rdata <= `ADCS_RD_UNMAPPED;
                end
            endcase
        end
    end

endmodule

// [tb/adcs_checker.sv]
/*
 * concurrent checks on the ports of the converter control block.
 * assumes it is bound into adcs_ctrl and sees nothing but its ports.
 */
`timescale 1ns/1ns

module adcs_checker (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       standby,
    input wire logic [3:0] addr,
    input wire logic       rd_en,
    input wire logic       wr_en,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ext_trigger_pin_n,
    input wire logic       cmp_high,
    input wire logic [9:0] dac_code,
    input wire logic       sample_hold,
    input wire logic [2:0] analog_chan_sel,
    input wire logic       conv_end_irq
);
    // --------------------------------------------------------------
    // helper logic
    // --------------------------------------------------------------
    // standby resets like rst_n, so both silence the checks
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n || standby);

    // length of the running sample window, cleared on the edge after it falls
    logic [7:0] win_len;
    always @(posedge clock) begin
        if (!rst_n || standby || !sample_hold) begin
            win_len <= 8'h00;
        end else begin
            win_len <= win_len + 8'h01;
        end
    end

    // a stop write may cut a window short, so such ends are excused
    sequence s_window_end;
        $fell(sample_hold) && !$past(wr_en && addr == 4'h8);
    endsequence
    // upper byte read followed at once by a lower byte read
    sequence s_pair_read;
        (rd_en && addr < 4'h8 && !addr[0]) ##1 (rd_en && addr < 4'h8 && addr[0]);
    endsequence

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    chk_reset_quiet: assert property ($past(!rst_n || standby) |->
        (rdata == 8'h00 && !conv_end_irq && analog_chan_sel == 3'h0 && !sample_hold))
        else $error("outputs not quiet after reset");
    chk_trig_ones: assert property (rd_en && addr == 4'h9 |=> rdata[6:0] == 7'h7f)
        else $error("trigger register low bits not all ones");
    chk_unmapped_zero: assert property (rd_en && addr > 4'h9 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_pair_low: assert property (s_pair_read |=> rdata[5:0] == 6'h00)
        else $error("lower result byte has bits below six set");
    chk_rdata_hold: assert property (!rd_en |=> $stable(rdata))
        else $error("read data changed without a read");
    chk_irq_gate: assert property (wr_en && addr == 4'h8 && !wdata[6] |=> !conv_end_irq)
        else $error("request stands with enable cleared");
    chk_flag_hold: assert property (conv_end_irq && !(wr_en && addr == 4'h8) |=> conv_end_irq)
        else $error("end request dropped without a status write");
    chk_chan_steady: assert property (sample_hold && $past(sample_hold)
        |-> $stable(analog_chan_sel))
        else $error("input selection moved during sampling");
    chk_window_len: assert property (s_window_end |-> win_len == 8'h50 || win_len == 8'h28)
        else $error("sample window length wrong");

    cover property (s_pair_read);
    cover property (s_window_end);
endmodule

bind adcs_ctrl adcs_checker u_chk (
    .clock(clock), .rst_n(rst_n), .standby(standby), .addr(addr), .rd_en(rd_en),
    .wr_en(wr_en), .wdata(wdata), .rdata(rdata), .ext_trigger_pin_n(ext_trigger_pin_n),
    .cmp_high(cmp_high), .dac_code(dac_code), .sample_hold(sample_hold),
    .analog_chan_sel(analog_chan_sel), .conv_end_irq(conv_end_irq)
);

// [tb/adcs_cmp_model.sv]
/*
 * comparator array seen by the converter: one fixed level per input.
 * assumes the block presents the selected input and the trial code.
 */
`timescale 1ns/1ns

module adcs_cmp_model (
    input  wire logic [2:0] analog_chan_sel,
    input  wire logic [9:0] dac_code,
    output wire logic       cmp_high
);
    // the input number sits in the top bits so a result filed in the
    // wrong register or taken from the wrong input shows at once
    function automatic logic [9:0] level(input logic [2:0] ch);
        level = {ch, 7'h55};
    endfunction

    // ideal comparison, high when the input is at or above the trial
    assign cmp_high = (level(analog_chan_sel) >= dac_code);
endmodule

// [tb/adcs_ctrl_tb_top.sv]
/*
 * self-checking bench of the converter control block with its comparator.
 * assumes the register map header and a one-cycle read latency.
 */
`timescale 1ns/1ns
`include "adcs_map.vh"

module adcs_ctrl_tb_top;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic       standby = 1'b0;
    logic [3:0] addr = 4'h0;
    logic       rd_en = 1'b0;
    logic       wr_en = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic       ext_trigger_pin_n = 1'b1;
    wire  [7:0] rdata;
    wire        cmp_high;
    wire  [9:0] dac_code;
    wire        sample_hold;
    wire  [2:0] analog_chan_sel;
    wire        conv_end_irq;
    integer     bad_count = 0;
    integer     check_count = 0;
    integer     i;
    logic [3:0] row_addr [0:10];
    logic [7:0] row_exp  [0:10];

    // --------------------------------------------------------------
    // clock, design and far side
    // --------------------------------------------------------------
    always #4 clock = ~clock;

    adcs_ctrl uut (
        .clock(clock), .rst_n(rst_n), .standby(standby), .addr(addr), .rd_en(rd_en),
        .wr_en(wr_en), .wdata(wdata), .rdata(rdata), .ext_trigger_pin_n(ext_trigger_pin_n),
        .cmp_high(cmp_high), .dac_code(dac_code), .sample_hold(sample_hold),
        .analog_chan_sel(analog_chan_sel), .conv_end_irq(conv_end_irq)
    );
    adcs_cmp_model u_cmp (
        .analog_chan_sel(analog_chan_sel), .dac_code(dac_code), .cmp_high(cmp_high)
    );

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    // strobes rise just after an edge and drop after the taking edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clock);
        #1;
        wr_en = 1'b0;
    endtask

    task automatic expect_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        #1;
        rd_en = 1'b1;
        addr = a;
        @(posedge clock);
        #1;
        rd_en = 1'b0;
        check(rdata, exp);
    endtask

    // bounded wait for the end request; running out ends the run
    task automatic wait_irq;
        integer n;
        n = 0;
        while (conv_end_irq !== 1'b1 && n < 600) begin
            @(posedge clock);
            #1;
            n = n + 1;
        end
        if (n >= 600) begin
            bad_count = bad_count + 1;
            $display("ERROR %0t no end request", $time);
            end_sim();
        end
    endtask

    // the pin idles high; only its falling edge counts
    task automatic pulse_pin;
        @(posedge clock);
        #1;
        ext_trigger_pin_n = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        ext_trigger_pin_n = 1'b1;
    endtask

    function automatic logic [7:0] res_byte(input logic [2:0] ch, input logic hi);
        logic [9:0] v;
        v = {ch, 7'h55};
        res_byte = hi ? v[9:2] : {v[1:0], 6'h00};
    endfunction

    task automatic table_pass;
        for (i = 0; i < 11; i = i + 1) begin
            expect_rd(row_addr[i], row_exp[i]);
        end
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        for (i = 0; i < 11; i = i + 1) begin
            row_addr[i] = (i < 10) ? i[3:0] : 4'hc;
            row_exp[i] = (i == 9) ? 8'h7f : 8'h00;
        end
        repeat (16) @(posedge clock);
        #1;
        rst_n = 1'b1;
        table_pass();
        // single slow conversion of input 1, request enabled
        wr(4'h8, 8'h61);
        expect_rd(4'h8, 8'h61);
        wait_irq();
        wr(4'h8, 8'h01);
        check({7'h00, conv_end_irq}, 8'h00);
        wr(4'h8, 8'h41);
        check({7'h00, conv_end_irq}, 8'h01);
        expect_rd(4'h8, 8'hc1);
        expect_rd(4'h2, res_byte(3'h1, 1'b1));
        expect_rd(4'h3, res_byte(3'h1, 1'b0));
        expect_rd(4'h1, res_byte(3'h1, 1'b0));
        wr(4'h8, 8'h41);
        expect_rd(4'h8, 8'h41);
        check({7'h00, conv_end_irq}, 8'h00);
        // fast single of input 6 started from the pin
        wr(4'h9, 8'h80);
        expect_rd(4'h9, 8'hff);
        wr(4'h8, 8'h4e);
        pulse_pin();
        wait_irq();
        expect_rd(4'h8, 8'hce);
        expect_rd(4'h4, res_byte(3'h6, 1'b1));
        expect_rd(4'h5, res_byte(3'h6, 1'b0));
        wr(4'h8, 8'h4e);
        wr(4'h9, 8'h00);
        expect_rd(4'h9, 8'h7f);
        pulse_pin();
        repeat (4) @(posedge clock);
        expect_rd(4'h8, 8'h4e);
        // fast scan over inputs 0 and 1, then a stop
        wr(4'h8, 8'h79);
        wait_irq();
        expect_rd(4'h8, 8'hf9);
        expect_rd(4'h0, res_byte(3'h0, 1'b1));
        expect_rd(4'h1, res_byte(3'h0, 1'b0));
        expect_rd(4'h2, res_byte(3'h1, 1'b1));
        wr(4'h8, 8'h59);
        repeat (2) @(posedge clock);
        expect_rd(4'h8, 8'h59);
        // standby restores every register
        @(posedge clock);
        #1;
        standby = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        standby = 1'b0;
        table_pass();
        end_sim();
    end
endmodule
